// *** hw/fault_log_pkg.sv ***
package fault_log_pkg;
   // register word offsets on the plain register port
   localparam logic [7:0] OFS_FAULT_ENTRY = 8'h00;
   localparam logic [7:0] OFS_FAULT_HOURS = 8'h10;
   localparam logic [7:0] OFS_RUN_HOURS = 8'h20;
   localparam logic [7:0] OFS_RUN_COUNT = 8'h21;
   localparam logic [7:0] OFS_FAN_HOURS = 8'h22;
   localparam logic [7:0] OFS_CAP_WEAR = 8'h23;
   localparam logic [7:0] OFS_SWITCH_WEAR = 8'h24;
   localparam logic [7:0] OFS_HOUR_PRESET = 8'h30;
   localparam logic [7:0] OFS_HOUR_COND = 8'h31;
   localparam logic [7:0] OFS_RUN_CLEAR = 8'h32;
   localparam logic [7:0] OFS_FAN_PRESET = 8'h33;
   localparam logic [7:0] OFS_CAP_CLEAR = 8'h34;
   localparam logic [7:0] OFS_SWITCH_CLEAR = 8'h35;
   localparam logic [7:0] OFS_CONTACT_SEL = 8'h36;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h38;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h39;

   localparam int HISTORY_DEPTH = 10;
   localparam int HOURS_W = 17;
   localparam int COUNT_W = 16;
   localparam int WEAR_W = 7;
   localparam int PRESCALE_W = 40;

   localparam logic [HOURS_W-1:0] HOUR_MAX = 17'h1_869F;
   localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hFFFF;
   localparam logic [WEAR_W-1:0] WEAR_MAX = 7'h64;
   localparam logic [WEAR_W-1:0] WEAR_ALARM_LOW = 7'h32;
   localparam logic [WEAR_W-1:0] WEAR_ALARM_HIGH = 7'h5A;
   localparam logic [7:0] SEL_WEAR_LOW = 8'h2F;
   localparam logic [7:0] SEL_WEAR_HIGH = 8'h10;

   // interrupt status bit positions
   localparam int IRQ_FAULT = 0;
   localparam int IRQ_HOUR_WRAP = 1;
   localparam int IRQ_RUN_WRAP = 2;
   localparam int IRQ_WEAR_LOW = 3;
   localparam int IRQ_WEAR_HIGH = 4;
   localparam int IRQ_W = 5;

   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 5'h00;
   localparam logic [7:0] CONTACT_SEL_RESET = 8'h00;
   localparam logic HOUR_COND_RESET = 1'b0;

   localparam longint HOUR_SECONDS = 3600;
   localparam longint CLK_HZ = 100_000_000;
   localparam longint HOUR_CYCLES = HOUR_SECONDS * CLK_HZ;
endpackage : fault_log_pkg

// *** hw/wrap_counter.sv ***
`timescale 1ns/1ns
module wrap_counter #(
   parameter int WIDTH = 16,
   parameter logic [WIDTH-1:0] MAX = '1
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic load,
   input wire logic [WIDTH-1:0] loadValue,
   input wire logic step,
   output logic [WIDTH-1:0] count,
   output logic wrapped
);
   logic [WIDTH-1:0] next_count;
   logic next_wrapped;

   // load beats a step in the same cycle
   always_comb begin
      next_count = count;
      next_wrapped = 1'b0;
      if (load) begin
         next_count = loadValue;
      end else if (step) begin
         if (count >= MAX) begin
            next_count = '0;
            next_wrapped = 1'b1;
         end else begin
            next_count = count + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count <= '0;
         wrapped <= 1'b0;
      end else begin
         count <= next_count;
         wrapped <= next_wrapped;
      end
   end
endmodule : wrap_counter

// *** hw/fault_log_and_wear_counters.sv ***
`timescale 1ns/1ns
// Overview of operation
// - ten fault codes kept, readable newest first down to the tenth newest
// - each entry keeps the operation hour count taken when it was logged
// - operation hour counter wraps to zero after 99999 hours
// - operation hour counter loads a value written to its preset setting
// - hour counter advances always, or only while run command active, by select
// - run command entries counted, wrapping to zero after 65535
// - writing the run count clear setting zeroes the run command count
// - fan hours count from preset setting, wrapping to zero after 65535
// - capacitor wear in 1% steps, cleared by its reset setting
// - contact output with select 2F closes when switch wear reaches 50%
// - contact output with select 10 closes when switch wear reaches 90%
// - switch wear reset setting clears switch wear to zero
// - these values are only readable, never an analog monitor source
module fault_log_and_wear_counters #(
   parameter int CODE_W = 16,
   parameter int CONTACTS = 2,
   parameter longint HOUR_CYCLES = fault_log_pkg::HOUR_CYCLES
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] address,
   input wire logic [31:0] writeData,
   input wire logic writeStrobe,
   input wire logic readStrobe,
   output logic [31:0] readData,
   output logic interrupt,
   input wire logic faultValid,
   input wire logic [CODE_W-1:0] faultCode,
   input wire logic runCommand,
   input wire logic fanRunning,
   input wire logic capWearStep,
   input wire logic switchWearStep,
   output logic [CONTACTS-1:0] contactOut
);
   import fault_log_pkg::*;

   localparam logic [PRESCALE_W-1:0] PRESCALE_MAX = PRESCALE_W'(HOUR_CYCLES - 1);

   logic [CODE_W-1:0] faultEntry [HISTORY_DEPTH];
   logic [HOURS_W-1:0] faultHours [HISTORY_DEPTH];
   logic [CODE_W-1:0] next_faultEntry [HISTORY_DEPTH];
   logic [HOURS_W-1:0] next_faultHours [HISTORY_DEPTH];
   logic runMeta, runLevel, runPrev, fanMeta, fanLevel;
   logic hourCond, next_hourCond;
   logic [7:0] contactSel [CONTACTS];
   logic [7:0] next_contactSel [CONTACTS];
   logic [IRQ_W-1:0] irqStatus, next_irqStatus, irqMask, next_irqMask, irqEvents;
   logic [WEAR_W-1:0] capWear, next_capWear, switchWear, next_switchWear;
   logic [31:0] next_readData;
   logic [CONTACTS-1:0] next_contactOut;
   logic next_interrupt;
   logic [HOURS_W-1:0] runHours;
   logic [COUNT_W-1:0] runCount, fanHours;
   logic hourEnable, hourTick, fanTick, hourWrap, runWrap, runRise;
   logic hourPresetWr, runClearWr, fanPresetWr, capClearWr, switchClearWr;

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; runMeta and fanMeta feed only their second stage
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         runMeta <= 1'b0;
         runLevel <= 1'b0;
         runPrev <= 1'b0;
         fanMeta <= 1'b0;
         fanLevel <= 1'b0;
      end else begin
         runMeta <= runCommand;
         runLevel <= runMeta;
         runPrev <= runLevel;
         fanMeta <= fanRunning;
         fanLevel <= fanMeta;
      end
   end

   assign runRise = runLevel & ~runPrev;
   assign hourPresetWr = writeStrobe && address == OFS_HOUR_PRESET;
   assign runClearWr = writeStrobe && address == OFS_RUN_CLEAR;
   assign fanPresetWr = writeStrobe && address == OFS_FAN_PRESET;
   assign capClearWr = writeStrobe && address == OFS_CAP_CLEAR;
   assign switchClearWr = writeStrobe && address == OFS_SWITCH_CLEAR;
   assign hourEnable = hourCond ? runLevel : 1'b1;

   ////////////////////////////////////////////////////////////////////////////////
   // hour prescalers and wrapping counters
   wrap_counter #(.WIDTH(PRESCALE_W), .MAX(PRESCALE_MAX)) hourPrescale (
      .clk(clk), .reset_n(reset_n), .load(hourPresetWr), .loadValue('0),
      .step(hourEnable), .count(), .wrapped(hourTick)
   );

   wrap_counter #(.WIDTH(PRESCALE_W), .MAX(PRESCALE_MAX)) fanPrescale (
      .clk(clk), .reset_n(reset_n), .load(fanPresetWr), .loadValue('0),
      .step(fanLevel), .count(), .wrapped(fanTick)
   );

   wrap_counter #(.WIDTH(HOURS_W), .MAX(HOUR_MAX)) runHourCounter (
      .clk(clk), .reset_n(reset_n), .load(hourPresetWr),
      .loadValue(writeData[HOURS_W-1:0]), .step(hourTick),
      .count(runHours), .wrapped(hourWrap)
   );

   // clear is a load of zero, so it beats an entry in the same cycle
   wrap_counter #(.WIDTH(COUNT_W), .MAX(COUNT_MAX)) runCounter (
      .clk(clk), .reset_n(reset_n), .load(runClearWr), .loadValue('0),
      .step(runRise), .count(runCount), .wrapped(runWrap)
   );

   wrap_counter #(.WIDTH(COUNT_W), .MAX(COUNT_MAX)) fanCounter (
      .clk(clk), .reset_n(reset_n), .load(fanPresetWr),
      .loadValue(writeData[COUNT_W-1:0]), .step(fanTick),
      .count(fanHours), .wrapped()
   );

   ////////////////////////////////////////////////////////////////////////////////
   // fault history
   always_comb begin
      next_faultEntry = faultEntry;
      next_faultHours = faultHours;
      if (faultValid) begin
         for (int i = HISTORY_DEPTH - 1; i > 0; i--) begin
            next_faultEntry[i] = faultEntry[i-1];
            next_faultHours[i] = faultHours[i-1];
         end
         next_faultEntry[0] = faultCode;
         next_faultHours[0] = runHours;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < HISTORY_DEPTH; i++) begin
            faultEntry[i] <= '0;
            faultHours[i] <= '0;
         end
      end else begin
         faultEntry <= next_faultEntry;
         faultHours <= next_faultHours;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // wear estimates, settings, interrupt status
   always_comb begin
      next_capWear = capWear;
      next_switchWear = switchWear;
      next_hourCond = hourCond;
      next_contactSel = contactSel;
      next_irqMask = irqMask;
      // estimates stop at 100 rather than wrap; a wrap would silence alarms
      if (capClearWr) begin
         next_capWear = '0;
      end else if (capWearStep && capWear < WEAR_MAX) begin
         next_capWear = capWear + 1'b1;
      end
      if (switchClearWr) begin
         next_switchWear = '0;
      end else if (switchWearStep && switchWear < WEAR_MAX) begin
         next_switchWear = switchWear + 1'b1;
      end
      if (writeStrobe && address == OFS_HOUR_COND) begin
         next_hourCond = writeData[0];
      end
      for (int i = 0; i < CONTACTS; i++) begin
         if (writeStrobe && address == OFS_CONTACT_SEL + 8'(i)) begin
            next_contactSel[i] = writeData[7:0];
         end
      end
      if (writeStrobe && address == OFS_IRQ_MASK) begin
         next_irqMask = writeData[IRQ_W-1:0];
      end
      irqEvents = '0;
      irqEvents[IRQ_FAULT] = faultValid;
      irqEvents[IRQ_HOUR_WRAP] = hourWrap;
      irqEvents[IRQ_RUN_WRAP] = runWrap;
      irqEvents[IRQ_WEAR_LOW] = next_switchWear >= WEAR_ALARM_LOW && switchWear < WEAR_ALARM_LOW;
      irqEvents[IRQ_WEAR_HIGH] = next_switchWear >= WEAR_ALARM_HIGH
         && switchWear < WEAR_ALARM_HIGH;
      // read clears, but an event in that same cycle still sets
      next_irqStatus = irqStatus;
      if (readStrobe && address == OFS_IRQ_STATUS) begin
         next_irqStatus = '0;
      end
      next_irqStatus = next_irqStatus | irqEvents;
      next_interrupt = |(irqStatus & irqMask);
      for (int i = 0; i < CONTACTS; i++) begin
         next_contactOut[i] = (contactSel[i] == SEL_WEAR_LOW && switchWear >= WEAR_ALARM_LOW)
            || (contactSel[i] == SEL_WEAR_HIGH && switchWear >= WEAR_ALARM_HIGH);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         capWear <= '0;
         switchWear <= '0;
         hourCond <= HOUR_COND_RESET;
         for (int i = 0; i < CONTACTS; i++) begin
            contactSel[i] <= CONTACT_SEL_RESET;
         end
         irqMask <= IRQ_MASK_RESET;
         irqStatus <= '0;
         interrupt <= 1'b0;
         contactOut <= '0;
      end else begin
         capWear <= next_capWear;
         switchWear <= next_switchWear;
         hourCond <= next_hourCond;
         contactSel <= next_contactSel;
         irqMask <= next_irqMask;
         irqStatus <= next_irqStatus;
         interrupt <= next_interrupt;
         contactOut <= next_contactOut;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read port; values leave only here, there is no analog path at all
   always_comb begin
      next_readData = '0;
      if (readStrobe) begin
         if (address[7:4] == OFS_FAULT_ENTRY[7:4] && address[3:0] < 4'(HISTORY_DEPTH)) begin
            next_readData[CODE_W-1:0] = faultEntry[address[3:0]];
         end else if (address[7:4] == OFS_FAULT_HOURS[7:4]
               && address[3:0] < 4'(HISTORY_DEPTH)) begin
            next_readData[HOURS_W-1:0] = faultHours[address[3:0]];
         end else begin
            unique case (address)
               OFS_RUN_HOURS: next_readData[HOURS_W-1:0] = runHours;
               OFS_RUN_COUNT: next_readData[COUNT_W-1:0] = runCount;
               OFS_FAN_HOURS: next_readData[COUNT_W-1:0] = fanHours;
               OFS_CAP_WEAR: next_readData[WEAR_W-1:0] = capWear;
               OFS_SWITCH_WEAR: next_readData[WEAR_W-1:0] = switchWear;
               OFS_HOUR_COND: next_readData[0] = hourCond;
               OFS_CONTACT_SEL: next_readData[7:0] = contactSel[0];
               OFS_CONTACT_SEL + 8'h01: next_readData[7:0] = contactSel[CONTACTS-1];
               OFS_IRQ_STATUS: next_readData[IRQ_W-1:0] = irqStatus;
               OFS_IRQ_MASK: next_readData[IRQ_W-1:0] = irqMask;
               default: next_readData = '0;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         readData <= '0;
      end else begin
         readData <= next_readData;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_fault_in;
      faultValid;
   endsequence

   sequence s_shifted;
      faultEntry[0] == $past(faultCode) && faultEntry[1] == $past(faultEntry[0])
         && faultEntry[HISTORY_DEPTH-1] == $past(faultEntry[HISTORY_DEPTH-2]);
   endsequence

   a_fault_shift: assert property (s_fault_in |=> s_shifted)
      else $error("fault history did not shift");
   a_fault_hours: assert property (faultValid |=> faultHours[0] == $past(runHours)
      && faultHours[1] == $past(faultHours[0]))
      else $error("fault hours not captured");
   a_fault_hold: assert property (!faultValid |=> $stable(faultEntry[0]))
      else $error("fault entry changed without fault");
   a_hour_wrap: assert property (hourTick && runHours == HOUR_MAX && !hourPresetWr
      |=> runHours == '0)
      else $error("hour counter did not wrap at 99999");
   a_hour_preset: assert property (hourPresetWr
      |=> runHours == $past(writeData[HOURS_W-1:0]))
      else $error("hour preset not loaded");
   a_hour_gate: assert property (hourCond && !runLevel |=> !hourTick)
      else $error("hour tick while not running");
   a_run_count: assert property (runRise && !runClearWr
      |=> runCount == $past(runCount) + 16'h0001)
      else $error("run entry not counted");
   a_run_clear: assert property (runClearWr |=> runCount == '0)
      else $error("run count not cleared");
   a_fan_wrap: assert property (fanTick && fanHours == COUNT_MAX && !fanPresetWr
      |=> fanHours == '0)
      else $error("fan hours did not wrap");
   a_cap_clear: assert property (capClearWr |=> capWear == '0)
      else $error("capacitor wear not cleared");
   a_contact_low: assert property (contactSel[0] == SEL_WEAR_LOW && switchWear >= WEAR_ALARM_LOW
      |=> contactOut[0])
      else $error("contact not closed at 50 percent");
   // late alarm watched on the last contact, where the bench selects it
   a_contact_high: assert property (contactSel[CONTACTS-1] == SEL_WEAR_HIGH
      && switchWear < WEAR_ALARM_HIGH |=> !contactOut[CONTACTS-1])
      else $error("contact closed below 90 percent");
   a_contact_close: assert property (contactSel[CONTACTS-1] == SEL_WEAR_HIGH
      && switchWear >= WEAR_ALARM_HIGH |=> contactOut[CONTACTS-1])
      else $error("contact not closed at 90 percent");

   sequence s_switch_zeroed;
      switchWear == '0 ##1 !contactOut[0];
   endsequence

   a_switch_clear: assert property (switchClearWr |=> s_switch_zeroed)
      else $error("switch wear not cleared");
   a_read_idle: assert property (!readStrobe |=> readData == '0)
      else $error("read data without read strobe");
endmodule : fault_log_and_wear_counters

// *** tb/tb_fault_log_and_wear_counters.sv ***
`timescale 1ns/1ns
module tb_fault_log_and_wear_counters;
   import fault_log_pkg::*;
   // short hour keeps wrap tests within a few hundred cycles
   localparam longint HOUR_TICKS = 10;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] address = 8'h00;
   logic [31:0] writeData = 32'h0000_0000;
   logic writeStrobe = 1'b0;
   logic readStrobe = 1'b0;
   logic [31:0] readData;
   logic interrupt;
   logic faultValid = 1'b0;
   logic [15:0] faultCode = 16'h0000;
   logic runCommand = 1'b0;
   logic fanRunning = 1'b0;
   logic capWearStep = 1'b0;
   logic switchWearStep = 1'b0;
   logic [1:0] contactOut;
   int mismatches = 0;
   int comparisons = 0;
   int cycles = 0;
   int n;
   int total;
   int stepPlan[5] = '{49, 1, 39, 1, 15};
   logic [31:0] seed = 32'h337d_a2cf;
   logic [15:0] codes[$];
   logic [16:0] hours[$];

   fault_log_and_wear_counters #(.CODE_W(16), .CONTACTS(2), .HOUR_CYCLES(HOUR_TICKS))
      i_fault_log_and_wear_counters (.clk(clk), .reset_n(reset_n), .address(address),
      .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
      .readData(readData), .interrupt(interrupt), .faultValid(faultValid),
      .faultCode(faultCode), .runCommand(runCommand), .fanRunning(fanRunning),
      .capWearStep(capWearStep), .switchWearStep(switchWearStep), .contactOut(contactOut));

   always #5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // wear saturates at full life
   function automatic logic [31:0] expected_wear(input int steps);
      return (steps > 100) ? 32'h0000_0064 : 32'(steps);
   endfunction : expected_wear

   // contact 0 selects the half-life alarm, contact 1 the late alarm
   function automatic logic [31:0] expected_contact(input int steps);
      return {30'h0, steps >= 90, steps >= 50};
   endfunction : expected_contact

   task automatic check_value(input string what, input logic [31:0] expected,
                              input logic [31:0] seen);
      comparisons++;
      if (seen !== expected) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, expected, seen);
      end
   endtask : check_value

   task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      address <= a;
      writeData <= d;
      writeStrobe <= 1'b1;
      @(posedge clk);
      writeStrobe <= 1'b0;
   endtask : write_reg

   // data stands only in the cycle after the strobe
   task automatic check_reg(input string what, input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      address <= a;
      readStrobe <= 1'b1;
      @(posedge clk);
      readStrobe <= 1'b0;
      #1 check_value(what, e, readData);
   endtask : check_reg

   task automatic log_fault(input logic [15:0] code);
      @(posedge clk);
      faultValid <= 1'b1;
      faultCode <= code;
      @(posedge clk);
      faultValid <= 1'b0;
   endtask : log_fault

   task automatic step_wear(input logic onSwitch, input int count);
      repeat (count) begin
         @(posedge clk);
         capWearStep <= !onSwitch;
         switchWearStep <= onSwitch;
         @(posedge clk);
         capWearStep <= 1'b0;
         switchWearStep <= 1'b0;
      end
   endtask : step_wear

   // pulses long enough to pass the pin synchroniser
   task automatic pulse_run(input int count);
      repeat (count) begin
         @(posedge clk);
         runCommand <= 1'b1;
         repeat (4) @(posedge clk);
         runCommand <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask : pulse_run

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : print_verdict

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         mismatches++;
         print_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      check_reg("hour condition", OFS_HOUR_COND, 32'h0000_0000);
      check_reg("contact select", OFS_CONTACT_SEL, 32'h0000_0000);
      check_reg("run count", OFS_RUN_COUNT, 32'h0000_0000);
      check_reg("unmapped", 8'h3F, 32'h0000_0000);
      write_reg(OFS_IRQ_MASK, 32'h0000_0001);
      check_reg("irq mask", OFS_IRQ_MASK, 32'h0000_0001);
      // freeze hours so each logged value is the preset just written
      write_reg(OFS_HOUR_COND, 32'h0000_0001);
      for (int i = 0; i < 11; i++) begin
         seed = lfsr(seed);
         write_reg(OFS_HOUR_PRESET, {16'h0000, seed[31:16]});
         hours.push_front({1'b0, seed[31:16]});
         codes.push_front(seed[15:0]);
         log_fault(seed[15:0]);
      end
      repeat (2) @(posedge clk);
      #1 check_value("interrupt", 32'h0000_0001, {31'h0, interrupt});
      check_reg("irq status", OFS_IRQ_STATUS, 32'h0000_0001);
      check_reg("irq status again", OFS_IRQ_STATUS, 32'h0000_0000);
      repeat (2) @(posedge clk);
      #1 check_value("interrupt low", 32'h0000_0000, {31'h0, interrupt});
      for (int i = 0; i < HISTORY_DEPTH; i++) begin
         check_reg("fault entry", OFS_FAULT_ENTRY + 8'(i), {16'h0000, codes[i]});
         check_reg("fault hours", OFS_FAULT_HOURS + 8'(i), {15'h0, hours[i]});
      end
      write_reg(OFS_HOUR_PRESET, 32'h0000_0005);
      repeat (30) @(posedge clk);
      check_reg("held hours", OFS_RUN_HOURS, 32'h0000_0005);
      // reads land mid-hour so prescaler phase does not matter
      write_reg(OFS_HOUR_COND, 32'h0000_0000);
      write_reg(OFS_HOUR_PRESET, 32'h0001_869E);
      repeat (14) @(posedge clk);
      check_reg("run hours max", OFS_RUN_HOURS, 32'h0001_869F);
      repeat (7) @(posedge clk);
      check_reg("run hours wrap", OFS_RUN_HOURS, 32'h0000_0000);
      check_reg("irq hour wrap", OFS_IRQ_STATUS, 32'h0000_0002);
      @(posedge clk);
      fanRunning <= 1'b1;
      write_reg(OFS_FAN_PRESET, 32'h0000_FFFE);
      repeat (14) @(posedge clk);
      check_reg("fan hours max", OFS_FAN_HOURS, 32'h0000_FFFF);
      repeat (7) @(posedge clk);
      check_reg("fan hours wrap", OFS_FAN_HOURS, 32'h0000_0000);
      @(posedge clk);
      fanRunning <= 1'b0;
      seed = lfsr(seed);
      n = int'(seed[2:0]) + 2;
      pulse_run(n);
      check_reg("run count", OFS_RUN_COUNT, 32'(n));
      write_reg(OFS_RUN_COUNT, 32'h0000_0000);
      check_reg("run count kept", OFS_RUN_COUNT, 32'(n));
      write_reg(OFS_RUN_CLEAR, seed);
      check_reg("run count clear", OFS_RUN_COUNT, 32'h0000_0000);
      seed = lfsr(seed);
      n = int'(seed[3:0]) + 1;
      step_wear(1'b0, n);
      check_reg("capacitor wear", OFS_CAP_WEAR, expected_wear(n));
      write_reg(OFS_CAP_CLEAR, seed);
      check_reg("capacitor clear", OFS_CAP_WEAR, 32'h0000_0000);
      write_reg(OFS_CONTACT_SEL, 32'h0000_002F);
      write_reg(OFS_CONTACT_SEL + 8'h01, 32'h0000_0010);
      check_reg("contact select 1", OFS_CONTACT_SEL + 8'h01, 32'h0000_0010);
      total = 0;
      // thresholds approached from one below, then past saturation
      foreach (stepPlan[k]) begin
         step_wear(1'b1, stepPlan[k]);
         total += stepPlan[k];
         repeat (2) @(posedge clk);
         #1 check_value("contacts", expected_contact(total), {30'h0, contactOut});
         check_reg("switch wear", OFS_SWITCH_WEAR, expected_wear(total));
      end
      // both wear crossings latched since the hour wrap status was read
      check_reg("irq wear", OFS_IRQ_STATUS, 32'h0000_0018);
      write_reg(OFS_SWITCH_CLEAR, 32'h0000_0000);
      check_reg("switch clear", OFS_SWITCH_WEAR, 32'h0000_0000);
      #1 check_value("contacts open", 32'h0000_0000, {30'h0, contactOut});
      print_verdict();
   end
endmodule : tb_fault_log_and_wear_counters
